// file: hw/iec_pkg.sv
// Purpose: Shared constants for the interrupt enable and flag block
// Assumes: AXI4-Lite register access, 32-bit data, byte address = 4 * index
// Notes: Registers are 8 bits wide in the low lane, upper bits read zero
package iec_pkg;
	localparam int unsigned ADDR_W = 12;
	// Printed offsets are register indexes, not byte addresses
	localparam logic [ADDR_W-1:0] IDX_PERIPH_EN = 12'h08c;
	localparam logic [ADDR_W-1:0] IDX_CORE_CTRL = 12'h10b;
	localparam logic [ADDR_W-1:0] ADDR_PERIPH_EN = ADDR_W'(IDX_PERIPH_EN * 4);
	localparam logic [ADDR_W-1:0] ADDR_CORE_CTRL = ADDR_W'(IDX_CORE_CTRL * 4);

	localparam logic [7:0] PERIPH_EN_RESET = 8'h00;
	localparam logic [7:0] CORE_CTRL_RESET = 8'h00;

	// Core control field positions
	localparam int unsigned BIT_MASTER_EN = 7;
	localparam int unsigned BIT_GROUP_EN = 6;
	localparam int unsigned BIT_T0_EN = 5;
	localparam int unsigned BIT_EXT_EN = 4;
	localparam int unsigned BIT_PCHG_EN = 3;
	localparam int unsigned BIT_T0_FLAG = 2;
	localparam int unsigned BIT_EXT_FLAG = 1;
	localparam int unsigned BIT_PCHG_FLAG = 0;

	// Peripheral enable field positions
	localparam int unsigned BIT_PAR_EN = 7;
	localparam int unsigned BIT_ADC_EN = 6;
	localparam int unsigned BIT_RX_EN = 5;
	localparam int unsigned BIT_TX_EN = 4;
	localparam int unsigned BIT_USB_EN = 3;
	localparam int unsigned BIT_CCP_EN = 2;
	localparam int unsigned BIT_T2_EN = 1;
	localparam int unsigned BIT_T1_EN = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		IEC_SEL_NONE = 2'b00,
		IEC_SEL_PERIPH = 2'b01,
		IEC_SEL_CORE = 2'b10
	} iec_sel_e;
endpackage : iec_pkg

// file: hw/iec_edge.sv
// Purpose: Edge detector for the external interrupt pin
// Assumes: Pin is synchronous to aclk
// Notes: Pulse is combinational, one cycle, qualified after first sample
`timescale 1ns/1ps
module iec_edge (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ext_irq_pin,
	input wire logic edge_select,
	output logic edge_pulse
);
	logic prev;
	logic armed;

	// No edge is reported until one sample has been seen after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev <= 1'b0;
			armed <= 1'b0;
		end else begin
			prev <= ext_irq_pin;
			armed <= 1'b1;
		end
	end

	always_comb begin
		edge_pulse = 1'b0;
		if (armed) begin
			edge_pulse = edge_select ? (ext_irq_pin & ~prev) : (~ext_irq_pin & prev);
		end
	end

	a_edge_rising: assert property (@(posedge aclk) disable iff (!aresetn)
		armed && edge_select && $rose(ext_irq_pin) |-> edge_pulse)
		else $error("rising edge missed");
	a_edge_falling: assert property (@(posedge aclk) disable iff (!aresetn)
		armed && !edge_select && $fell(ext_irq_pin) |-> edge_pulse)
		else $error("falling edge missed");
endmodule : iec_edge

// file: hw/iec_top.sv
// Purpose: Interrupt enable and flag registers with one core interrupt request
// Assumes: AXI4-Lite slave, one outstanding read and write, events are pulses
// Notes: Flags are set by hardware and cleared only by software writes
// Notes on behaviour
// - External pin interrupt requests only when its enable is 1; flag still records.
// - Peripheral sources never reach the core without the group enable.
// - Peripheral enable register: one enable per source, bits 7..0, reset zero.
// - Parallel port enable bit 7 gates the parallel port event.
// - Converter enable bit 6 gates conversion complete.
// - Serial transmit enable bit 4 gates transmit buffer empty.
// - Flags set on their event regardless of any enable bit.
// - External flag on rising edge if edge_select is 1, else falling.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module iec_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [iec_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [iec_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer0_ovf_evt,
	input wire logic ext_irq_pin,
	input wire logic edge_select,
	input wire logic port_change_evt,
	input wire logic [7:0] periph_flag,
	output logic core_irq
);
	logic [7:0] core_ctrl;
	logic [7:0] next_core_ctrl;
	logic [7:0] periph_en;
	logic [7:0] next_periph_en;
	logic next_core_irq;
	logic ext_evt;
	logic core_pend;
	logic periph_pend;

	logic aw_held;
	logic next_aw_held;
	logic w_held;
	logic next_w_held;
	logic [iec_pkg::ADDR_W-1:0] aw_addr;
	logic [iec_pkg::ADDR_W-1:0] next_aw_addr;
	logic [7:0] w_data;
	logic [7:0] next_w_data;
	logic w_lane0;
	logic next_w_lane0;
	logic next_awready;
	logic next_wready;
	logic [1:0] next_bresp;
	logic next_bvalid;
	logic next_arready;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_rvalid;
	logic do_write;

	function automatic iec_pkg::iec_sel_e decode(input logic [iec_pkg::ADDR_W-1:0] addr);
		if (addr == iec_pkg::ADDR_PERIPH_EN) begin
			return iec_pkg::IEC_SEL_PERIPH;
		end else if (addr == iec_pkg::ADDR_CORE_CTRL) begin
			return iec_pkg::IEC_SEL_CORE;
		end
		return iec_pkg::IEC_SEL_NONE;
	endfunction : decode

	iec_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_irq_pin(ext_irq_pin),
		.edge_select(edge_select),
		.edge_pulse(ext_evt)
	);

	// Bus channels
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bresp = s_axi_bresp;
		next_bvalid = s_axi_bvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_rvalid = s_axi_rvalid;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// Write commits once both halves are held and no response is pending
		if (aw_held && w_held && !s_axi_bvalid) begin
			do_write = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (decode(aw_addr) == iec_pkg::IEC_SEL_NONE) ? iec_pkg::RESP_SLVERR : iec_pkg::RESP_OKAY;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = iec_pkg::RESP_OKAY;
			unique case (decode(s_axi_araddr))
				iec_pkg::IEC_SEL_PERIPH: next_rdata = {24'h000000, periph_en};
				iec_pkg::IEC_SEL_CORE: next_rdata = {24'h000000, core_ctrl};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = iec_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bresp <= iec_pkg::RESP_OKAY;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= iec_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bresp <= next_bresp;
			s_axi_bvalid <= next_bvalid;
			s_axi_arready <= next_arready;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_rvalid <= next_rvalid;
		end
	end

	// Enables, flags and request
	always_comb begin
		next_core_ctrl = core_ctrl;
		next_periph_en = periph_en;
		if (do_write && w_lane0 && decode(aw_addr) == iec_pkg::IEC_SEL_CORE) begin
			next_core_ctrl = w_data;
		end
		if (do_write && w_lane0 && decode(aw_addr) == iec_pkg::IEC_SEL_PERIPH) begin
			next_periph_en = w_data;
		end
		// Event ORed after the write so a set in the clearing cycle wins
		next_core_ctrl[iec_pkg::BIT_T0_FLAG] = next_core_ctrl[iec_pkg::BIT_T0_FLAG] | timer0_ovf_evt;
		next_core_ctrl[iec_pkg::BIT_EXT_FLAG] = next_core_ctrl[iec_pkg::BIT_EXT_FLAG] | ext_evt;
		next_core_ctrl[iec_pkg::BIT_PCHG_FLAG] = next_core_ctrl[iec_pkg::BIT_PCHG_FLAG] | port_change_evt;
		core_pend = (core_ctrl[iec_pkg::BIT_T0_EN] & core_ctrl[iec_pkg::BIT_T0_FLAG])
			| (core_ctrl[iec_pkg::BIT_EXT_EN] & core_ctrl[iec_pkg::BIT_EXT_FLAG])
			| (core_ctrl[iec_pkg::BIT_PCHG_EN] & core_ctrl[iec_pkg::BIT_PCHG_FLAG]);
		periph_pend = core_ctrl[iec_pkg::BIT_GROUP_EN] & (|(periph_en & periph_flag));
		next_core_irq = core_ctrl[iec_pkg::BIT_MASTER_EN] & (core_pend | periph_pend);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_ctrl <= iec_pkg::CORE_CTRL_RESET;
			periph_en <= iec_pkg::PERIPH_EN_RESET;
			core_irq <= 1'b0;
		end else begin
			core_ctrl <= next_core_ctrl;
			periph_en <= next_periph_en;
			core_irq <= next_core_irq;
		end
	end

	a_ext_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
		core_ctrl[7] && core_ctrl[4] && core_ctrl[1] |=> core_irq)
		else $error("enabled pin interrupt not requested");
	a_ext_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		!core_ctrl[4] && !(core_ctrl[5] && core_ctrl[2]) && !(core_ctrl[3] && core_ctrl[0]) && !periph_pend
		|=> !core_irq)
		else $error("masked pin interrupt requested");
	a_group_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!core_ctrl[6] && !core_pend |=> !core_irq)
		else $error("peripheral passed without group enable");
	a_periph_reset: assert property (@(posedge aclk)
		!aresetn |=> periph_en == iec_pkg::PERIPH_EN_RESET && core_irq == 1'b0)
		else $error("enable register not zero after reset");
	a_par_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		core_ctrl[7] && core_ctrl[6] && periph_en[7] && periph_flag[7] |=> core_irq)
		else $error("parallel port interrupt lost");
	a_adc_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		core_ctrl[7] && core_ctrl[6] && periph_en[6] && periph_flag[6] |=> core_irq)
		else $error("converter interrupt lost");
	a_tx_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		core_ctrl[7] && core_ctrl[6] && periph_en[4] && periph_flag[4] |=> core_irq)
		else $error("transmit interrupt lost");
	a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		timer0_ovf_evt || port_change_evt |=> (core_ctrl[2] || !$past(timer0_ovf_evt))
		&& (core_ctrl[0] || !$past(port_change_evt)))
		else $error("event flag not set");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		core_ctrl[1] && !do_write |=> core_ctrl[1])
		else $error("flag cleared without write");
	a_master_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!core_ctrl[7] |=> !core_irq)
		else $error("request without master enable");
endmodule : iec_top

// file: bench/iec_evt_src.sv
// Purpose: Event sources facing the interrupt block
// Assumes: Sources change right after a rising edge
// Notes: Pulses last one cycle; levels hold until changed
`timescale 1ns/1ps
module iec_evt_src (
	input wire logic aclk,
	output logic timer0_ovf_evt,
	output logic ext_irq_pin,
	output logic edge_select,
	output logic port_change_evt,
	output logic [7:0] periph_flag
);
	initial begin
		timer0_ovf_evt = 1'b0;
		port_change_evt = 1'b0;
		ext_irq_pin = 1'b0;
		edge_select = 1'b1;
		periph_flag = 8'h00;
	end
	task automatic pulse(input logic pc);
		@(posedge aclk);
		timer0_ovf_evt <= !pc;
		port_change_evt <= pc;
		@(posedge aclk);
		timer0_ovf_evt <= 1'b0;
		port_change_evt <= 1'b0;
	endtask : pulse
	task automatic level(input logic pin, input logic sel, input logic [7:0] pf);
		@(posedge aclk);
		ext_irq_pin <= pin;
		edge_select <= sel;
		periph_flag <= pf;
	endtask : level
endmodule : iec_evt_src

// file: bench/iec_top_tb.sv
// Purpose: Self-checking bench for the interrupt block
// Assumes: Registered AXI answers, event to request in two cycles
// Notes: Ready is looked at on the falling edge, taken on the next rising edge
`timescale 1ns/1ps
module iec_top_tb;
	localparam logic [11:0] PE = iec_pkg::ADDR_PERIPH_EN;
	localparam logic [11:0] CC = iec_pkg::ADDR_CORE_CTRL;
	localparam logic [1:0] OK = iec_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = iec_pkg::RESP_SLVERR;
	typedef struct {logic [7:0] pf, pe, cc; logic irq;} iec_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic timer0_ovf_evt, ext_irq_pin, edge_select, port_change_evt;
	logic [7:0] periph_flag;
	int mismatches = 0, total_checks = 0, cycles = 0;
	iec_row_s rows [10] = '{'{8'h80, 8'h80, 8'hc0, 1'b1}, '{8'h80, 8'h7f, 8'hc0, 1'b0},
		'{8'h40, 8'h40, 8'hc0, 1'b1}, '{8'h10, 8'h10, 8'h80, 1'b0}, '{8'h10, 8'h10, 8'hc0, 1'b1},
		'{8'h10, 8'h10, 8'h40, 1'b0}, '{8'hff, 8'h00, 8'hc0, 1'b0}, '{8'h24, 8'hdb, 8'hc0, 1'b0},
		'{8'h0a, 8'h0a, 8'hc0, 1'b1}, '{8'h01, 8'h01, 8'hc0, 1'b1}};
	always #2 aclk = ~aclk;
	iec_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_ovf_evt, .ext_irq_pin,
		.edge_select, .port_change_evt, .periph_flag, .core_irq);
	iec_evt_src u_src (.aclk, .timer0_ovf_evt, .ext_irq_pin, .edge_select, .port_change_evt, .periph_flag);
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_word
	task automatic cmp_bit(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : cmp_bit
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			aw_d = aw_d | (s_axi_awvalid & s_axi_awready);
			w_d = w_d | (s_axi_wvalid & s_axi_wready);
			@(posedge aclk);
			if (aw_d) s_axi_awvalid <= 1'b0;
			if (w_d) s_axi_wvalid <= 1'b0;
		end while (!(aw_d && w_d));
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		cmp_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		cmp_word("rdata", ed, s_axi_rdata);
		cmp_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// Generous ceiling; the whole run needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(PE, 32'h0, OK);
		rd(CC, 32'h0, OK);
		$display("Reset test done");
		for (int i = 0; i < 10; i++) begin
			u_src.level(1'b0, 1'b1, rows[i].pf);
			wr(PE, rows[i].pe, 4'hf, OK);
			wr(CC, rows[i].cc, 4'hf, OK);
			repeat (3) @(negedge aclk);
			cmp_bit("core_irq", rows[i].irq, core_irq);
			rd(PE, {24'h0, rows[i].pe}, OK);
			$display("Row %0d done", i);
		end
		u_src.level(1'b0, 1'b1, 8'h00);
		wr(CC, 8'h00, 4'hf, OK);
		u_src.level(1'b1, 1'b1, 8'h00);
		rd(CC, 32'h02, OK);
		cmp_bit("core_irq", 1'b0, core_irq);
		wr(CC, 8'h92, 4'hf, OK);
		repeat (3) @(negedge aclk);
		cmp_bit("core_irq", 1'b1, core_irq);
		wr(CC, 8'h82, 4'hf, OK);
		repeat (3) @(negedge aclk);
		cmp_bit("core_irq", 1'b0, core_irq);
		rd(CC, 32'h82, OK);
		wr(CC, 8'h00, 4'hf, OK);
		u_src.level(1'b1, 1'b0, 8'h00);
		u_src.level(1'b0, 1'b0, 8'h00);
		rd(CC, 32'h02, OK);
		wr(CC, 8'h00, 4'hf, OK);
		u_src.level(1'b1, 1'b0, 8'h00);
		rd(CC, 32'h00, OK);
		$display("External pin test done");
		wr(CC, 8'ha8, 4'hf, OK);
		u_src.pulse(1'b0);
		repeat (3) @(negedge aclk);
		cmp_bit("core_irq", 1'b1, core_irq);
		u_src.pulse(1'b1);
		rd(CC, 32'had, OK);
		$display("Timer and port test done");
		// Overflow lands on the edge that commits the clearing write
		fork
			wr(CC, 8'h00, 4'hf, OK);
			begin
				@(posedge aclk);
				u_src.pulse(1'b0);
			end
		join
		rd(CC, 32'h04, OK);
		$display("Set over clear test done");
		wr(12'h004, 8'hff, 4'hf, ERR);
		rd(12'h004, 32'h0, ERR);
		wr(PE, 8'hff, 4'h0, OK);
		rd(PE, 32'h01, OK);
		$display("Bus refusal test done");
		u_src.level(1'b1, 1'b1, 8'hff);
		wr(CC, 8'hc0, 4'hf, OK);
		repeat (3) @(negedge aclk);
		cmp_bit("core_irq", 1'b1, core_irq);
		// Pin held high across reset must not look like a rising edge
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		cmp_bit("core_irq", 1'b0, core_irq);
		rd(PE, 32'h0, OK);
		rd(CC, 32'h0, OK);
		$display("Mid-run reset test done");
		conclude();
	end
endmodule : iec_top_tb
